// ---- hw/bsc_map.svh ----
// Functional notes
// R01 - Scene recall drives blind to stored percent
// R02 - Scene recall moves slats to stored percent
// R03 - Safety engages when value equals chosen polarity
// R04 - Safety engage applies unchanged, up, down, stop
// R05 - Stop de-energises both motor relays at once
// R06 - Missing safety telegram within monitor time engages
// R07 - Monitor time zero disables watchdog entirely
// R08 - Tool reset clears any active safety
// R09 - Safety survives supply return until released
// R10 - Second safety input with identical settings
// R11 - Release applies unchanged, up, down, stop, preset
// R12 - Unchanged release keeps relays and running motion
// R13 - Supply loss sets relays as configured
// R14 - Up/down on supply loss is best effort
// R15 - Supply recovery applies configured relay reaction
// R16 - Referencing disabled ignores reference requests
// R17 - No-reaction mode parks at reference end
// R18 - Return mode drives back to recorded position
// R19 - Automatic resumes only after recorded position reached
// R20 - Position command during referencing runs afterwards
// R21 - Scene byte: index minus one, plus 128 stores
// R22 - Direct positioning drives straight to target
// R23 - Safety blocks ordinary commands; release after all clear
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

`define BSC_CLK_HZ 100000000
`define BSC_MON_UNIT_S 1
`define BSC_SEC_CYCLES (`BSC_CLK_HZ * `BSC_MON_UNIT_S)
`define BSC_TRAVEL_MS 60000
`define BSC_STEP_CYCLES ((`BSC_CLK_HZ / 1000 / 100) * `BSC_TRAVEL_MS)

`define BSC_OFS_CTRL 6'h00
`define BSC_OFS_MON 6'h01
`define BSC_OFS_STATUS 6'h02
`define BSC_OFS_PRESET 6'h03
`define BSC_OFS_SLOT0 6'h08
`define BSC_NUM_SLOTS 8

`define BSC_CTRL_RST 32'h0000010D
`define BSC_CTRL_MASK 32'h00007FFF
`define BSC_SLOT_MASK 32'h007F7F7F
`define BSC_PRESET_MASK 32'h00007F7F

`define BSC_B_SAF_EN 0
`define BSC_B_POL 2
`define BSC_F_TRIG 5:4
`define BSC_F_REL 8:6
`define BSC_F_FAIL 10:9
`define BSC_F_RECOV 12:11
`define BSC_F_REF 14:13
`define BSC_F_MON_A 15:0
`define BSC_F_MON_B 31:16
`define BSC_F_NUM 6:0
`define BSC_F_POS 14:8
`define BSC_F_SLAT 22:16

`define BSC_PCT_MAX 7'h64
`define BSC_STORE_BIT 7

`endif

// ---- hw/bsc_pkg.sv ----
package bsc_pkg;

    typedef enum logic [3:0] {
        BSC_IDLE = 4'h1,
        BSC_UP = 4'h2,
        BSC_DOWN = 4'h4,
        BSC_POS = 4'h8
    } bsc_mode_t;

    // Reaction codes shared by safety, release and supply events.
    typedef enum logic [2:0] {
        BSC_ACT_KEEP = 3'h0,
        BSC_ACT_UP = 3'h1,
        BSC_ACT_DOWN = 3'h2,
        BSC_ACT_STOP = 3'h3,
        BSC_ACT_PRESET = 3'h4
    } bsc_act_t;

    typedef enum logic [1:0] {
        BSC_REF_OFF = 2'h0,
        BSC_REF_STAY = 2'h1,
        BSC_REF_RETURN = 2'h2
    } bsc_ref_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bsc_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } bsc_wb_rsp_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [31:0] ctrl;
        logic [31:0] mon;
        logic [31:0] preset;
        logic [7:0][31:0] slot;
        logic [31:0] sec_cnt;
        logic [31:0] step_cnt;
        logic [1:0] saf;
        logic [1:0][15:0] wd;
        bsc_mode_t mode;
        logic [6:0] pos;
        logic [6:0] slat;
        logic [6:0] tpos;
        logic [6:0] tslat;
        logic ref_busy;
        logic [6:0] ref_pos;
        logic [6:0] ref_slat;
        logic pend_v;
        logic [6:0] pend_pos;
        logic [6:0] pend_slat;
        logic auto_on;
        logic auto_was;
        logic auto_wait;
        logic rly_up;
        logic rly_down;
    } bsc_state_t;

endpackage

// ---- hw/bsc_blind_ctrl.sv ----
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_map.svh"

module bsc_blind_ctrl #(
    parameter int unsigned SEC_CYCLES = `BSC_SEC_CYCLES,
    parameter int unsigned STEP_CYCLES = `BSC_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire bsc_pkg::bsc_wb_req_t wb_req_i,
    output bsc_pkg::bsc_wb_rsp_t wb_rsp_o,
    // Safety telegrams, bit 0 is input A and bit 1 input B
    input wire logic [1:0] saf_stb_i,
    input wire logic [1:0] saf_val_i,
    // Movement telegrams
    input wire logic move_stb_i,
    input wire logic move_down_i,
    input wire logic stop_stb_i,
    input wire logic pos_stb_i,
    input wire logic [7:0] target_position_command_i,
    input wire logic [7:0] slat_command_i,
    // Automatic operation
    input wire logic auto_set_i,
    input wire logic auto_val_i,
    input wire logic auto_stb_i,
    input wire logic [7:0] auto_pos_i,
    input wire logic [7:0] auto_slat_i,
    // Scene, reference and system events
    input wire logic scene_stb_i,
    input wire logic [7:0] scene_byte_i,
    input wire logic ref_stb_i,
    input wire logic tool_reset_i,
    input wire logic supply_loss_event_i,
    input wire logic supply_back_i,
    // Motor relays
    output logic relay_up_o,
    output logic relay_down_o
);
    import bsc_pkg::*;

    bsc_state_t s;
    bsc_state_t next_s;
    logic acc;
    logic sec_tick;
    logic step_tick;
    logic was_saf;
    logic now_saf;
    logic [6:0] sc_no;
    logic [31:0] wr_word;

    // Converts a 0..255 telegram value to whole percent, rounded.
    function automatic logic [6:0] pct_of(input logic [7:0] v);
        logic [15:0] t;
        t = ({8'h00, v} * 16'h0064 + 16'h007F) / 16'h00FF;
        return t[6:0];
    endfunction

    // Stored percentages are clamped so a bad register write cannot overrun.
    function automatic logic [6:0] clamp(input logic [6:0] v);
        return (v > `BSC_PCT_MAX) ? `BSC_PCT_MAX : v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Fixed reactions; keep returns the running mode so motion finishes.
    function automatic bsc_mode_t react(input logic [2:0] a, input bsc_mode_t cur);
        case (a)
            BSC_ACT_UP: return BSC_UP;
            BSC_ACT_DOWN: return BSC_DOWN;
            BSC_ACT_STOP: return BSC_IDLE;
            default: return cur;
        endcase
    endfunction

    assign acc = wb_req_i.cyc && wb_req_i.stb && !s.ack;
    assign sec_tick = (s.sec_cnt == 32'(SEC_CYCLES - 1));
    assign step_tick = (s.step_cnt == 32'(STEP_CYCLES - 1));
    assign was_saf = |s.saf;
    assign sc_no = {1'b0, scene_byte_i[5:0]} + 7'h01;
    assign wr_word = wb_req_i.dat;

    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        now_saf = 1'b0;

        // Register slave: one-cycle ack the edge after the request appears.
        if (acc) begin
            next_s.ack = 1'b1;
            next_s.rdat = 32'h00000000;
            case (wb_req_i.adr[7:2])
                `BSC_OFS_CTRL: begin
                    next_s.rdat = s.ctrl;
                    if (wb_req_i.we) begin
                        next_s.ctrl = merge(s.ctrl, wr_word, wb_req_i.sel) & `BSC_CTRL_MASK;
                    end
                end
                `BSC_OFS_MON: begin
                    next_s.rdat = s.mon;
                    if (wb_req_i.we) begin
                        next_s.mon = merge(s.mon, wr_word, wb_req_i.sel);
                    end
                end
                `BSC_OFS_STATUS: begin
                    next_s.rdat = {10'h000, s.auto_on, s.rly_down, s.rly_up, s.ref_busy, s.saf,
                                   1'b0, s.slat, 1'b0, s.pos};
                end
                `BSC_OFS_PRESET: begin
                    next_s.rdat = s.preset;
                    if (wb_req_i.we) begin
                        next_s.preset = merge(s.preset, wr_word, wb_req_i.sel) & `BSC_PRESET_MASK;
                    end
                end
                default: begin
                    if (wb_req_i.adr[7:5] == 3'h1) begin
                        next_s.rdat = s.slot[wb_req_i.adr[4:2]];
                        if (wb_req_i.we) begin
                            next_s.slot[wb_req_i.adr[4:2]] =
                                merge(s.slot[wb_req_i.adr[4:2]], wr_word, wb_req_i.sel) & `BSC_SLOT_MASK;
                        end
                    end
                end
            endcase
        end

        next_s.sec_cnt = sec_tick ? 32'h00000000 : s.sec_cnt + 32'h00000001;
        next_s.step_cnt = step_tick ? 32'h00000000 : s.step_cnt + 32'h00000001;

        // Safety inputs A and B share one code path with their own settings.
        for (int i = 0; i < 2; i++) begin
            if (!s.ctrl[`BSC_B_SAF_EN + i]) begin
                next_s.saf[i] = 1'b0; // R10
                next_s.wd[i] = 16'h0000;
            end else if (saf_stb_i[i]) begin
                next_s.wd[i] = 16'h0000;
                next_s.saf[i] = (saf_val_i[i] == s.ctrl[`BSC_B_POL + i]); // R03 R09
            end else if (sec_tick && s.mon[i*16 +: 16] != 16'h0000) begin // R07
                // The shared second tick can fire up to one second late, but never early.
                if (s.wd[i] >= s.mon[i*16 +: 16]) begin
                    next_s.saf[i] = 1'b1; // R06
                end else begin
                    next_s.wd[i] = s.wd[i] + 16'h0001;
                end
            end
        end
        // A tool reset outranks every safety source in the same cycle.
        if (tool_reset_i) begin
            next_s.saf = 2'b00; // R08
            next_s.wd = '0;
        end
        now_saf = |next_s.saf;

        // Motion model: one percent per step tick, position first then slats.
        if (step_tick) begin
            case (s.mode)
                BSC_UP: begin
                    if (s.pos != 7'h00) begin
                        next_s.pos = s.pos - 7'h01;
                    end else begin
                        next_s.mode = BSC_IDLE;
                    end
                end
                BSC_DOWN: begin
                    if (s.pos != `BSC_PCT_MAX) begin
                        next_s.pos = s.pos + 7'h01;
                    end else begin
                        next_s.mode = BSC_IDLE;
                    end
                end
                BSC_POS: begin // R22
                    if (s.pos > s.tpos) begin
                        next_s.pos = s.pos - 7'h01;
                    end else if (s.pos < s.tpos) begin
                        next_s.pos = s.pos + 7'h01;
                    end else if (s.slat > s.tslat) begin
                        next_s.slat = s.slat - 7'h01;
                    end else if (s.slat < s.tslat) begin
                        next_s.slat = s.slat + 7'h01;
                    end else begin
                        next_s.mode = BSC_IDLE;
                        if (s.auto_wait) begin
                            next_s.auto_on = 1'b1; // R19
                            next_s.auto_wait = 1'b0;
                        end
                    end
                end
                BSC_IDLE: begin
                end
                default: next_s.mode = BSC_IDLE;
            endcase
        end

        // Reference run ends at the upper end stop.
        if (s.ref_busy && next_s.mode == BSC_IDLE && s.pos == 7'h00) begin
            next_s.ref_busy = 1'b0;
            if (s.pend_v) begin
                next_s.pend_v = 1'b0; // R20
                next_s.tpos = s.pend_pos;
                next_s.tslat = s.pend_slat;
                next_s.mode = BSC_POS;
            end else if (s.ctrl[`BSC_F_REF] == BSC_REF_RETURN) begin
                next_s.tpos = s.ref_pos; // R18
                next_s.tslat = s.ref_slat;
                next_s.mode = BSC_POS;
                next_s.auto_wait = s.auto_was; // R19
            end // R17
        end else if (s.ref_busy && s.mode == BSC_IDLE) begin
            // A reference run cut short by a stop is dropped so later commands are not held forever.
            next_s.ref_busy = 1'b0;
            next_s.pend_v = 1'b0;
        end

        // Ordinary commands only while no safety input is engaged.
        if (!was_saf && !now_saf) begin // R23
            if (move_stb_i) begin
                next_s.mode = move_down_i ? BSC_DOWN : BSC_UP;
            end
            if (stop_stb_i) begin
                next_s.mode = BSC_IDLE;
            end
            if (auto_set_i) begin
                next_s.auto_on = auto_val_i;
                next_s.auto_wait = 1'b0;
            end
            if (pos_stb_i || (auto_stb_i && s.auto_on)) begin
                if (next_s.ref_busy) begin
                    next_s.pend_v = 1'b1; // R20
                    next_s.pend_pos = pos_stb_i ? pct_of(target_position_command_i) : pct_of(auto_pos_i);
                    next_s.pend_slat = pos_stb_i ? pct_of(slat_command_i) : pct_of(auto_slat_i);
                end else begin
                    next_s.tpos = pos_stb_i ? pct_of(target_position_command_i) : pct_of(auto_pos_i);
                    next_s.tslat = pos_stb_i ? pct_of(slat_command_i) : pct_of(auto_slat_i);
                    next_s.mode = BSC_POS; // R22
                end
            end
            if (scene_stb_i && !scene_byte_i[6]) begin
                for (int k = 0; k < `BSC_NUM_SLOTS; k++) begin
                    if (s.slot[k][`BSC_F_NUM] == sc_no) begin // R21
                        if (scene_byte_i[`BSC_STORE_BIT]) begin
                            next_s.slot[k][`BSC_F_POS] = s.pos;
                            next_s.slot[k][`BSC_F_SLAT] = s.slat;
                        end else begin
                            next_s.tpos = clamp(s.slot[k][`BSC_F_POS]); // R01
                            next_s.tslat = clamp(s.slot[k][`BSC_F_SLAT]); // R02
                            next_s.mode = BSC_POS;
                        end
                    end
                end
            end
            // The reference run always approaches the upper end stop.
            if (ref_stb_i && !s.ref_busy && s.ctrl[`BSC_F_REF] != BSC_REF_OFF) begin // R16
                next_s.ref_busy = 1'b1;
                next_s.ref_pos = s.pos;
                next_s.ref_slat = s.slat;
                next_s.auto_was = s.auto_on;
                next_s.auto_on = 1'b0;
                next_s.pend_v = 1'b0;
                next_s.mode = BSC_UP;
            end
        end

        if (!was_saf && now_saf) begin
            next_s.mode = react({1'b0, s.ctrl[`BSC_F_TRIG]}, next_s.mode); // R04 R05
        end else if (was_saf && !now_saf) begin
            if (s.ctrl[`BSC_F_REL] == BSC_ACT_PRESET) begin // R11
                next_s.tpos = clamp(s.preset[6:0]);
                next_s.tslat = clamp(s.preset[14:8]);
                next_s.mode = BSC_POS;
            end else begin
                next_s.mode = react(s.ctrl[`BSC_F_REL], next_s.mode); // R11 R12
            end
        end

        // Up or down may not complete if the reserve energy is already spent.
        if (supply_loss_event_i) begin
            next_s.mode = react({1'b0, s.ctrl[`BSC_F_FAIL]}, next_s.mode); // R13 R14
        end
        // Safety flags are left alone here so they persist across recovery.
        if (supply_back_i) begin
            next_s.mode = react({1'b0, s.ctrl[`BSC_F_RECOV]}, next_s.mode); // R15 R09
        end

        next_s.rly_up = (next_s.mode == BSC_UP) || (next_s.mode == BSC_POS &&
            (next_s.pos > next_s.tpos || (next_s.pos == next_s.tpos && next_s.slat > next_s.tslat)));
        next_s.rly_down = (next_s.mode == BSC_DOWN) || (next_s.mode == BSC_POS &&
            (next_s.pos < next_s.tpos || (next_s.pos == next_s.tpos && next_s.slat < next_s.tslat)));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.ctrl <= `BSC_CTRL_RST;
            s.mode <= BSC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp_o.ack = s.ack;
    assign wb_rsp_o.dat = s.rdat;
    assign relay_up_o = s.rly_up;
    assign relay_down_o = s.rly_down;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_relays_exclusive: assert property (!(relay_up_o && relay_down_o)) // R05
        else $error("both motor relays energised");
    a_stop_on_engage: assert property ($rose(|s.saf) && s.ctrl[`BSC_F_TRIG] == 2'h3
        && !$past(supply_loss_event_i || supply_back_i) |-> !relay_up_o && !relay_down_o) // R05
        else $error("stop reaction left a relay on");
    a_up_on_engage: assert property ($rose(|s.saf) && s.ctrl[`BSC_F_TRIG] == 2'h1 |-> relay_up_o
        || $past(supply_loss_event_i || supply_back_i)) // R04
        else $error("up reaction not applied");
    a_polarity_a: assert property (saf_stb_i[0] && s.ctrl[0] && saf_val_i[0] == s.ctrl[2]
        && !tool_reset_i |=> s.saf[0]) // R03
        else $error("safety A did not engage on trigger level");
    a_release_a: assert property (saf_stb_i[0] && saf_val_i[0] != s.ctrl[2] |=> !s.saf[0]) // R09
        else $error("safety A held after releasing value");
    a_input_b: assert property (saf_stb_i[1] && s.ctrl[1] && saf_val_i[1] == s.ctrl[3]
        && !tool_reset_i |=> s.saf[1]) // R10
        else $error("safety B did not engage on trigger level");
    a_tool_clear: assert property (tool_reset_i |=> s.saf == 2'b00) // R08
        else $error("tool reset left safety active");
    a_wd_disabled: assert property (!s.saf[0] && s.mon[15:0] == 16'h0000 && !saf_stb_i[0]
        |=> !s.saf[0]) // R07
        else $error("watchdog fired with zero monitor time");
    a_cmd_blocked: assert property ((|s.saf) && pos_stb_i && !s.ref_busy && !supply_back_i
        |=> s.tpos == $past(s.tpos) || $past(!(|next_s.saf))) // R23
        else $error("position taken during safety");
    a_ref_holds: assert property (s.ref_busy && pos_stb_i && !(|s.saf) && !(|next_s.saf)
        && s.mode == BSC_UP && s.pos != 7'h00 |=> s.pend_v) // R20
        else $error("position during reference not held");

    c_scene_recall: cover property (scene_stb_i && !scene_byte_i[7] && !(|s.saf) ##1 s.mode == BSC_POS);
    c_safety_engage: cover property ($rose(|s.saf));
    c_ref_done: cover property ($fell(s.ref_busy) ##1 s.mode == BSC_POS);
    c_ref_pending: cover property (s.pend_v ##1 (!s.pend_v && s.mode == BSC_POS));
    c_preset_release: cover property ($fell(|s.saf) && s.mode == BSC_POS);

endmodule // bsc_blind_ctrl

`default_nettype wire

// ---- tb/bsc_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none

module bsc_far_end (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Motor relays
    input wire logic relay_up_i,
    input wire logic relay_down_i,
    // Observations
    output logic [15:0] motor_steps_o,
    output logic [7:0] clash_o
);
    // The motor turns only while exactly one relay is energised.
    // Both at once would short the winding, so every such cycle is counted.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            motor_steps_o <= 16'h0000;
            clash_o <= 8'h00;
        end else begin
            if (relay_up_i && relay_down_i) begin
                clash_o <= clash_o + 8'h01;
            end
            if (relay_down_i && !relay_up_i) begin
                motor_steps_o <= motor_steps_o + 16'h0001;
            end else if (relay_up_i && !relay_down_i && motor_steps_o != 16'h0000) begin
                motor_steps_o <= motor_steps_o - 16'h0001;
            end
        end
    end
endmodule // bsc_far_end

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import bsc_pkg::*;
    localparam int unsigned SEC = 10;
    localparam int unsigned STEP = 4;
    typedef struct packed {
        logic b;
        logic pol;
        logic [1:0] act;
        logic up;
        logic dn;
    } bsc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    bsc_wb_req_t wb_req = '0;
    bsc_wb_rsp_t wb_rsp;
    logic [1:0] saf_stb = 2'h0;
    logic [1:0] saf_val = 2'h0;
    logic move_stb = 1'b0;
    logic move_down = 1'b0;
    logic stop_stb = 1'b0;
    logic pos_stb = 1'b0;
    logic [7:0] tgt = 8'h00;
    logic scene_stb = 1'b0;
    logic [7:0] scene_byte = 8'h00;
    logic ref_stb = 1'b0;
    logic tool_reset = 1'b0;
    logic loss = 1'b0;
    logic back = 1'b0;
    logic auto_set = 1'b0;
    logic rly_up;
    logic rly_dn;
    logic [15:0] steps;
    logic [7:0] clash;
    logic [31:0] rd;
    int err_count = 0;
    int checks = 0;
    bsc_row_t rows [4] = '{'{1'b0, 1'b1, 2'h0, 1'b0, 1'b1}, '{1'b1, 1'b0, 2'h1, 1'b1, 1'b0},
                           '{1'b0, 1'b0, 2'h2, 1'b0, 1'b1}, '{1'b1, 1'b1, 2'h3, 1'b0, 1'b0}};

    always #5 clk_i = ~clk_i;

    bsc_blind_ctrl #(.SEC_CYCLES(SEC), .STEP_CYCLES(STEP)) i_bsc_blind_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .saf_stb_i(saf_stb), .saf_val_i(saf_val), .move_stb_i(move_stb), .move_down_i(move_down),
        .stop_stb_i(stop_stb), .pos_stb_i(pos_stb), .target_position_command_i(tgt), .slat_command_i(tgt),
        .auto_set_i(auto_set), .auto_val_i(move_down), .auto_stb_i(1'b0), .auto_pos_i(8'h00), .auto_slat_i(8'h00),
        .scene_stb_i(scene_stb), .scene_byte_i(scene_byte), .ref_stb_i(ref_stb), .tool_reset_i(tool_reset),
        .supply_loss_event_i(loss), .supply_back_i(back), .relay_up_o(rly_up), .relay_down_o(rly_dn));

    bsc_far_end i_bsc_far_end (
        .clk_i(clk_i), .rst_i(rst_i), .relay_up_i(rly_up), .relay_down_i(rly_dn),
        .motor_steps_o(steps), .clash_o(clash));

    task automatic finish_test();
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // The request is held until the edge at which ack is seen high; that edge also takes the read data.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        rd = wb_rsp.dat;
        wb_req <= '0;
        chk(n < 50, "bus timeout");
    endtask

    // One-cycle event strobe; k 8 and 9 are safety telegrams on input A and B, 10 sets automatic to d[0].
    task automatic ev(input int k, input logic [7:0] d);
        @(posedge clk_i);
        move_down <= d[0];
        saf_val <= {d[0], d[0]};
        scene_byte <= d;
        tgt <= d;
        case (k)
            0: move_stb <= 1'b1;
            1: stop_stb <= 1'b1;
            2: pos_stb <= 1'b1;
            3: scene_stb <= 1'b1;
            4: ref_stb <= 1'b1;
            5: tool_reset <= 1'b1;
            6: loss <= 1'b1;
            7: back <= 1'b1;
            10: auto_set <= 1'b1;
            default: saf_stb <= 2'(k - 7);
        endcase
        @(posedge clk_i);
        {move_stb, stop_stb, pos_stb, scene_stb, ref_stb, tool_reset, loss, back, auto_set, saf_stb} <= '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic relays(input logic up, input logic dn, input string msg);
        idle(2);
        chk(rly_up === up && rly_dn === dn, msg);
    endtask

    task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
        int n;
        n = 0;
        do begin
            wb(1'b0, 8'h08, 32'h0);
            n++;
        end while ((rd & mask) !== val && n < 400);
        chk((rd & mask) === val, "status did not reach expected value");
    endtask

    initial begin
        #1_000_000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        logic [31:0] ctrl;
        logic [31:0] p;
        logic [15:0] s;
        bsc_row_t r;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk(rd === 32'h0000010D && rly_up === 1'b0 && rly_dn === 1'b0, "reset state");
        wb(1'b1, 8'hFC, 32'hFFFFFFFF);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rd === 32'h00000000, "unmapped read not zero");
        // Engage reaction per row with the release left unchanged.
        for (int i = 0; i < 4; i++) begin
            r = rows[i];
            ctrl = 32'h0;
            ctrl[r.b] = 1'b1;
            ctrl[2 + r.b] = r.pol;
            ctrl[5:4] = r.act;
            wb(1'b1, 8'h00, ctrl);
            ev(0, 8'h01);
            idle(40);
            ev(8 + r.b, {7'h0, r.pol});
            relays(r.up, r.dn, "engage reaction");
            ev(0, 8'h00);
            ev(2, 8'h00);
            relays(r.up, r.dn, "command not blocked by safety");
            ev(8 + r.b, {7'h0, ~r.pol});
            relays(r.up, r.dn, "unchanged release altered relays");
            ev(1, 8'h00);
            relays(1'b0, 1'b0, "stop left a relay on");
            s = steps;
            idle(5);
            chk(steps === s, "motor still turning after stop");
        end
        for (int k = 1; k < 4; k++) begin
            wb(1'b1, 8'h00, 32'h00000005 | (32'(k) << 6));
            ev(0, 8'h01);
            ev(8, 8'h01);
            ev(8, 8'h00);
            relays(k == 1, k == 2, "release reaction");
            ev(1, 8'h00);
        end
        wb(1'b1, 8'h0C, 32'h00000305);
        wb(1'b1, 8'h00, 32'h00000105);
        ev(8, 8'h01);
        ev(8, 8'h00);
        wait_stat(32'h00007F7F, 32'h00000305);
        wb(1'b1, 8'h04, 32'h00000002);
        ev(8, 8'h00);
        idle(12);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[16] === 1'b0, "watchdog fired early");
        idle(20);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[16] === 1'b1, "watchdog did not fire");
        ev(5, 8'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[16] === 1'b0, "tool reset kept safety");
        wb(1'b1, 8'h04, 32'h00000000);
        idle(40);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[16] === 1'b0, "watchdog active with zero time");
        wb(1'b1, 8'h00, 32'h00000C05);
        ev(6, 8'h00);
        relays(1'b0, 1'b1, "supply loss reaction");
        ev(7, 8'h00);
        relays(1'b1, 1'b0, "supply recovery reaction");
        ev(1, 8'h00);
        ev(8, 8'h01);
        ev(6, 8'h00);
        ev(7, 8'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[16] === 1'b1, "safety lost over supply return");
        ev(8, 8'h00);
        ev(1, 8'h00);
        wb(1'b1, 8'h20, 32'h00010218);
        ev(3, 8'h17);
        wait_stat(32'h00007F7F, 32'h00000102);
        ev(0, 8'h01);
        idle(30);
        ev(1, 8'h00);
        wb(1'b0, 8'h08, 32'h0);
        p = rd;
        ev(3, 8'h97);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd[14:8] === p[6:0] && rd[22:16] === p[14:8], "scene store");
        wb(1'b1, 8'h00, 32'h00000005);
        ev(4, 8'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[18] === 1'b0, "reference ran while disabled");
        wb(1'b1, 8'h00, 32'h00004005);
        wb(1'b1, 8'h20, 32'h00010218);
        ev(3, 8'h17);
        wait_stat(32'h00007F7F, 32'h00000102);
        ev(10, 8'h01);
        ev(4, 8'h00);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd[18] === 1'b1 && rd[21] === 1'b0, "reference run not started");
        wait_stat(32'h0024007F, 32'h00200002);
        wb(1'b1, 8'h00, 32'h00002005);
        ev(4, 8'h00);
        ev(2, 8'h33);
        wait_stat(32'h00047F7F, 32'h00001414);
        ev(4, 8'h00);
        wait_stat(32'h0004007F, 32'h00000000);
        chk(clash === 8'h00, "both relays energised");
        finish_test();
    end
endmodule // testbench

`default_nettype wire
